// ### core/sdct_cmd_timing.sv
// Device side of the SDRAM command, clock-enable and data-mask timing
//
// Timing rules, for this block and for its controller
// RL1 - A READ or WRITE is accepted on every clock; column commands back to back.
// RL2 - Clock suspend or power-down starts one clock after clock enable sampled low.
// RL3 - Operation resumes one clock after clock enable returns high.
// RL4 - Write data mask applies to data of the same clock; masked bytes dropped.
// RL5 - Read outputs go high impedance two clocks after mask sampled asserted.
// RL6 - Controller gives first write word on the WRITE command clock.
// RL7 - Auto precharge: controller waits 4 or 5 clocks before ACTIVE to bank.
// RL8 - Controller waits two clocks from last write word to PRECHARGE.
// RL9 - Burst stop may follow last wanted write word by one clock.
// RL10 - New READ or WRITE may follow last write word by one clock.
// RL11 - Two clocks from mode load to ACTIVE or refresh.
// RL12 - PRECHARGE stops read data: high impedance after 3 or 2 clocks per latency.
// RL13 - Controller waits 100us after power-up, then issues two AUTO REFRESH.
// RL14 - Controller repeats the two-refresh wake-up when refresh interval exceeded; the model tracks no interval and runs it only once.
// RL15 - Clock frequency stays constant during accesses; clock enable may slow data.
// RL16 - Clock toggles at least twice during self-refresh exit wait.
// RL17 - Controller derives recovery clock counts from nanosecond figures, rounding up.
`timescale 1ns/1ps
module sdct_cmd_timing (
    // Clock and reset
    input  wire logic                            clock,
    input  wire logic                            resetn,
    // Command pins
    input  wire logic                            cke,
    input  wire logic                            csN,
    input  wire logic                            rasN,
    input  wire logic                            casN,
    input  wire logic                            weN,
    input  wire logic [sdct_pkg::BANK_W-1:0]     ba,
    input  wire logic [sdct_pkg::ADDR_W-1:0]     addr,
    // Data pins
    input  wire logic [sdct_pkg::BYTES-1:0]      dqm,
    input  wire logic [sdct_pkg::DATA_W-1:0]     dqIn,
    output logic      [sdct_pkg::DATA_W-1:0]     dqOut,
    output logic      [sdct_pkg::BYTES-1:0]      dqOe,
    // Status
    output logic                                 suspended,
    output logic                                 selfRefresh,
    output logic                                 writeOverflow
);
    // ==========================================================
    // Declarations
    localparam int MW = sdct_pkg::BANK_W + sdct_pkg::COL_W;

    logic [3:0]                       cmd;
    logic                             cmdEn;
    logic                             rdLoad;
    logic                             wrPush;
    logic                             preHit;
    logic [MW-1:0]                    wrAddr;
    logic [sdct_pkg::BURST_W-1:0]     lastWord;

    logic                             ckePrev_ff;
    logic [2:0]                       readLat_ff;
    logic [2:0]                       burstCode_ff;
    sdct_pkg::sdct_burst_t            state_ff;
    logic [sdct_pkg::BURST_W-1:0]     burstLeft_ff;
    logic [sdct_pkg::COL_W-1:0]       colPtr_ff;
    logic [sdct_pkg::BANK_W-1:0]      bankPtr_ff;
    logic [sdct_pkg::DATA_W-1:0]      pipe0Data_ff;
    logic [sdct_pkg::DATA_W-1:0]      pipe1Data_ff;
    logic                             pipe0Vld_ff;
    logic                             pipe1Vld_ff;
    logic [sdct_pkg::BYTES-1:0]       dqmDly1_ff;
    logic [sdct_pkg::BYTES-1:0]       dqmDly2_ff;
    logic [sdct_pkg::DATA_W-1:0]      dqOut_ff;
    logic [sdct_pkg::BYTES-1:0]       dqOe_ff;
    logic                             suspended_ff;
    logic                             selfRefresh_ff;
    logic                             overflow_ff;

    logic [sdct_pkg::DATA_W-1:0]      mem [sdct_pkg::MEM_WORDS];

    sdct_stream_if #(.WIDTH(sdct_pkg::ENTRY_W)) pushIf ();
    sdct_stream_if #(.WIDTH(sdct_pkg::ENTRY_W)) popIf ();

    // ==========================================================
    // Command decode
    assign cmd      = {csN, rasN, casN, weN};
    // Commands and data are taken only when the previous edge saw enable high
    assign cmdEn    = ckePrev_ff; // [RL2] [RL3]
    assign lastWord = sdct_pkg::sdct_last_word(burstCode_ff);
    assign preHit   = (cmd == sdct_pkg::CMD_PRE)
                    && (addr[sdct_pkg::PRE_ALL_BIT] || (ba == bankPtr_ff));
    assign rdLoad   = cmdEn && (state_ff == sdct_pkg::BURST_READ);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ckePrev_ff   <= 1'b0;
            suspended_ff <= 1'b1;
        end else begin
            ckePrev_ff   <= cke; // [RL2] [RL3]
            suspended_ff <= !cke;
        end
    end

    // ==========================================================
    // Mode register load
    always_ff @(posedge clock) begin
        if (!resetn) begin
            readLat_ff   <= sdct_pkg::RST_READ_LAT;
            burstCode_ff <= sdct_pkg::RST_BURST_CODE;
        end else if (cmdEn && cmd == sdct_pkg::CMD_LMR) begin
            burstCode_ff <= addr[sdct_pkg::MR_BL_LSB +: 3];
            // Unsupported latencies keep the old setting
            if (addr[sdct_pkg::MR_LAT_LSB +: 3] == sdct_pkg::LAT_TWO ||
                addr[sdct_pkg::MR_LAT_LSB +: 3] == sdct_pkg::LAT_THREE) begin
                readLat_ff <= addr[sdct_pkg::MR_LAT_LSB +: 3];
            end
        end
    end

    // ==========================================================
    // Self refresh: refresh command on the edge that sees enable fall
    always_ff @(posedge clock) begin
        if (!resetn) begin
            selfRefresh_ff <= 1'b0;
        end else if (cmdEn && !cke && cmd == sdct_pkg::CMD_REF) begin
            selfRefresh_ff <= 1'b1;
        end else if (cke) begin
            selfRefresh_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Burst engine; any new column command cuts the running burst
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_ff     <= sdct_pkg::BURST_IDLE;
            burstLeft_ff <= '0;
            colPtr_ff    <= '0;
            bankPtr_ff   <= '0;
        end else if (cmdEn) begin
            if (cmd == sdct_pkg::CMD_RD) begin
                state_ff     <= sdct_pkg::BURST_READ; // [RL1]
                bankPtr_ff   <= ba;
                colPtr_ff    <= addr[sdct_pkg::COL_W-1:0];
                burstLeft_ff <= lastWord;
            end else if (cmd == sdct_pkg::CMD_WR) begin
                // First word already taken with the command
                state_ff     <= (lastWord == '0) ? sdct_pkg::BURST_IDLE
                                                 : sdct_pkg::BURST_WRITE; // [RL1] [RL6]
                bankPtr_ff   <= ba;
                colPtr_ff    <= addr[sdct_pkg::COL_W-1:0] + 1'b1;
                burstLeft_ff <= lastWord - 1'b1;
            end else if (cmd == sdct_pkg::CMD_BST ||
                         (preHit && state_ff != sdct_pkg::BURST_IDLE)) begin
                // Word loaded on this edge still leaves the pipe
                state_ff <= sdct_pkg::BURST_IDLE; // [RL12]
            end else if (state_ff != sdct_pkg::BURST_IDLE) begin
                if (burstLeft_ff == '0) begin
                    state_ff <= sdct_pkg::BURST_IDLE;
                end else begin
                    burstLeft_ff <= burstLeft_ff - 1'b1;
                end
                colPtr_ff <= colPtr_ff + 1'b1;
            end
        end
    end

    // ==========================================================
    // Write path into the FIFO, mask travels with its own word
    assign wrPush = cmdEn && ((cmd == sdct_pkg::CMD_WR) ||
                    ((state_ff == sdct_pkg::BURST_WRITE) && cmd != sdct_pkg::CMD_RD &&
                     cmd != sdct_pkg::CMD_BST && cmd != sdct_pkg::CMD_PRE));
    assign wrAddr = (cmd == sdct_pkg::CMD_WR) ?
                    {ba, addr[sdct_pkg::COL_W-1:0]} : {bankPtr_ff, colPtr_ff};
    assign pushIf.valid = wrPush;
    assign pushIf.data  = {wrAddr, dqm, dqIn}; // [RL4] [RL6]

    // Overflow is sticky until reset; data is lost, never stalled
    always_ff @(posedge clock) begin
        if (!resetn) begin
            overflow_ff <= 1'b0;
        end else if (wrPush && !pushIf.ready) begin
            overflow_ff <= 1'b1;
        end
    end

    sdct_fifo #(
        .WIDTH (sdct_pkg::ENTRY_W),
        .DEPTH (sdct_pkg::FIFO_DEPTH)
    ) u_wfifo (
        .clock   (clock),
        .resetn  (resetn),
        .inPort  (pushIf),
        .outPort (popIf)
    );

    // Single-port array: reads win, writes wait in the FIFO
    assign popIf.ready = !rdLoad;

    always_ff @(posedge clock) begin
        if (popIf.valid && popIf.ready) begin
            for (int b = 0; b < sdct_pkg::BYTES; b++) begin
                if (!popIf.data[sdct_pkg::DATA_W + b]) begin
                    mem[popIf.data[sdct_pkg::ENTRY_W-1 -: MW]][b*8 +: 8] <=
                        popIf.data[b*8 +: 8]; // [RL4]
                end
            end
        end
    end

    // ==========================================================
    // Read pipe and output stage, frozen while suspended
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pipe0Vld_ff  <= 1'b0;
            pipe1Vld_ff  <= 1'b0;
            pipe0Data_ff <= '0;
            pipe1Data_ff <= '0;
        end else if (cmdEn) begin
            pipe0Vld_ff  <= rdLoad;
            pipe0Data_ff <= mem[{bankPtr_ff, colPtr_ff}];
            pipe1Vld_ff  <= pipe0Vld_ff;
            pipe1Data_ff <= pipe0Data_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            dqmDly1_ff <= '0;
            dqmDly2_ff <= '0;
        end else if (cmdEn) begin
            dqmDly1_ff <= dqm; // [RL5]
            dqmDly2_ff <= dqmDly1_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            dqOut_ff <= '0;
            dqOe_ff  <= '0;
        end else if (cmdEn) begin
            if (readLat_ff == sdct_pkg::LAT_TWO) begin
                dqOut_ff <= pipe0Data_ff;
                dqOe_ff  <= {sdct_pkg::BYTES{pipe0Vld_ff}} & ~dqmDly2_ff; // [RL5] [RL12]
            end else begin
                dqOut_ff <= pipe1Data_ff;
                dqOe_ff  <= {sdct_pkg::BYTES{pipe1Vld_ff}} & ~dqmDly2_ff; // [RL5] [RL12]
            end
        end
    end

    assign dqOut         = dqOut_ff;
    assign dqOe          = dqOe_ff;
    assign suspended     = suspended_ff;
    assign selfRefresh   = selfRefresh_ff;
    assign writeOverflow = overflow_ff;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    property p_read_each_clock;
        (cmdEn && cmd == sdct_pkg::CMD_RD) ##1 (cmdEn && cmd == sdct_pkg::CMD_RD)
        |=> pipe0Vld_ff ##1 pipe0Vld_ff;
    endproperty
    a_read_each_clock: assert property (p_read_each_clock) // [RL1]
        else $error("Back to back reads did not both load data");

    property p_write_burst_word;
        (cmdEn && cmd == sdct_pkg::CMD_WR && burstCode_ff != sdct_pkg::RST_BURST_CODE)
        ##1 (cmdEn && cmd == sdct_pkg::CMD_NOP) |-> pushIf.valid;
    endproperty
    a_write_burst_word: assert property (p_write_burst_word) // [RL1]
        else $error("Second write burst word not taken");

    property p_suspend_entry;
        (cmdEn && !cke) |=> !cmdEn ##1 ($stable(dqOut_ff) && $stable(state_ff));
    endproperty
    a_suspend_entry: assert property (p_suspend_entry) // [RL2]
        else $error("State moved during clock suspend");

    property p_resume;
        (!cmdEn && cke) |=> cmdEn && !suspended_ff;
    endproperty
    a_resume: assert property (p_resume) // [RL3]
        else $error("Did not resume one clock after enable high");

    property p_write_mask;
        wrPush && (cmd == sdct_pkg::CMD_WR)
        |-> pushIf.data[sdct_pkg::DATA_W +: sdct_pkg::BYTES] == dqm
            && pushIf.data[sdct_pkg::DATA_W-1:0] == dqIn;
    endproperty
    a_write_mask: assert property (p_write_mask) // [RL4]
        else $error("Write mask not tied to same clock data");

    property p_dqm_hiz;
        (cmdEn && dqm[0]) ##1 cmdEn ##1 cmdEn |=> !dqOe_ff[0];
    endproperty
    a_dqm_hiz: assert property (p_dqm_hiz) // [RL5]
        else $error("Byte 0 driven two clocks after mask");

    property p_pre_hiz_lat3;
        (cmdEn && cmd == sdct_pkg::CMD_PRE && addr[sdct_pkg::PRE_ALL_BIT]
         && readLat_ff == sdct_pkg::LAT_THREE)
        ##1 (cmdEn && cmd == sdct_pkg::CMD_NOP)[*3] |=> dqOe_ff == '0;
    endproperty
    a_pre_hiz_lat3: assert property (p_pre_hiz_lat3) // [RL12]
        else $error("Outputs driven three clocks after precharge");

    property p_pre_hiz_lat2;
        (cmdEn && cmd == sdct_pkg::CMD_PRE && addr[sdct_pkg::PRE_ALL_BIT]
         && readLat_ff == sdct_pkg::LAT_TWO)
        ##1 (cmdEn && cmd == sdct_pkg::CMD_NOP)[*2] |=> dqOe_ff == '0;
    endproperty
    a_pre_hiz_lat2: assert property (p_pre_hiz_lat2) // [RL12]
        else $error("Outputs driven two clocks after precharge");

    c_read_burst: cover property (rdLoad ##1 rdLoad ##1 rdLoad ##1 rdLoad);
    c_suspend_read: cover property (rdLoad && !cke ##1 !cmdEn ##1 cmdEn);
    c_fifo_full: cover property (wrPush && !pushIf.ready);
    c_pre_cut: cover property ((state_ff == sdct_pkg::BURST_READ) && cmdEn && preHit);
endmodule

// ### core/sdct_pkg.sv
// Shared constants and types of the SDRAM command timing core
package sdct_pkg;

    // ==========================================================
    // Widths and sizes
    localparam int DATA_W     = 64;
    localparam int BYTES      = 8;
    localparam int BANK_W     = 2;
    localparam int ADDR_W     = 13;
    localparam int COL_W      = 6;
    localparam int MEM_WORDS  = 256;
    localparam int FIFO_DEPTH = 32;
    localparam int ENTRY_W    = DATA_W + BYTES + BANK_W + COL_W;
    localparam int BURST_W    = 9;

    // ==========================================================
    // Command codes {csN, rasN, casN, weN}
    localparam logic [3:0] CMD_LMR = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_RD  = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // ==========================================================
    // Address and mode field positions
    localparam int PRE_ALL_BIT = 10;
    localparam int MR_BL_LSB   = 0;
    localparam int MR_LAT_LSB  = 4;

    // ==========================================================
    // Mode encodings and reset values
    localparam logic [2:0] LAT_TWO        = 3'h2;
    localparam logic [2:0] LAT_THREE      = 3'h3;
    localparam logic [2:0] RST_READ_LAT   = 3'h3;
    localparam logic [2:0] RST_BURST_CODE = 3'h0;
    localparam logic [2:0] BL_FULL_PAGE   = 3'h7;
    localparam logic [BURST_W-1:0] FULL_PAGE_LAST = 9'h1FF;

    // ==========================================================
    // Cycle counts
    localparam int DQM_READ_CYCLES = 2;
    localparam int DQM_WRITE_CYCLES = 0;

    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_READ,
        BURST_WRITE
    } sdct_burst_t;

    // Burst length code to index of last word
    function automatic logic [BURST_W-1:0] sdct_last_word(input logic [2:0] code);
        logic [BURST_W-1:0] res;
        res = 9'h000;
        unique case (code)
            3'h0: res = 9'h000;
            3'h1: res = 9'h001;
            3'h2: res = 9'h003;
            3'h3: res = 9'h007;
            BL_FULL_PAGE: res = FULL_PAGE_LAST;
            default: res = 9'h000;
        endcase
        return res;
    endfunction

endpackage

// ### core/sdct_stream_if.sv
// Valid/ready stream carrier between the core and its write FIFO
`timescale 1ns/1ps
interface sdct_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ### core/sdct_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sdct_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic    clock,
    input wire logic    resetn,
    // Streams
    sdct_stream_if.snk  inPort,
    sdct_stream_if.src  outPort
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wrPtr_ff;
    logic [AW:0]      rdPtr_ff;
    logic             full;
    logic             empty;

    assign full  = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
    assign empty = (wrPtr_ff == rdPtr_ff);
    assign inPort.ready  = !full;
    assign outPort.valid = !empty;
    assign outPort.data  = store[rdPtr_ff[AW-1:0]];

    always_ff @(posedge clock) begin
        if (inPort.valid && !full) begin
            store[wrPtr_ff[AW-1:0]] <= inPort.data;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wrPtr_ff <= '0;
        end else if (inPort.valid && !full) begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rdPtr_ff <= '0;
        end else if (outPort.ready && !empty) begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
        end
    end
endmodule

// ### verif/sdct_ctrl_model.sv
// Controller model driving the SDRAM command and data pins
`timescale 1ns/1ps
module sdct_ctrl_model (
    // Clock
    input  wire logic        clock,
    // Command pins
    output logic             cke,
    output logic             csN,
    output logic             rasN,
    output logic             casN,
    output logic             weN,
    output logic [1:0]       ba,
    output logic [12:0]      addr,
    // Data pins
    output logic [7:0]       dqm,
    output logic [63:0]      dqIn
);
    // ==========================================================
    // Spacing kept by the controller
    localparam int INIT_CYCLES = 20000;  // 100 us at 5 ns
    localparam int GAP_WR      = 2;      // Meets stop, column and precharge
    localparam int GAP_WR_ACT  = 5;      // Auto precharge only, never used here
    localparam int GAP_LMR     = 2;

    logic       ckeNext;
    logic [1:0] bankNext;

    initial begin
        ckeNext = 1'b1;
        bankNext = 2'h0;
        cke = 1'b1;
        {csN, rasN, casN, weN} = sdct_pkg::CMD_NOP;
        ba = 2'h0;
        addr = 13'h0000;
        dqm = 8'h00;
        dqIn = 64'h0;
    end

    // ==========================================================
    // Command tasks, one command per clock
    task automatic issue(input logic [3:0] op, input logic [12:0] a,
                         input logic [7:0] m, input logic [63:0] d);
        @(negedge clock);
        cke = ckeNext;
        {csN, rasN, casN, weN} = op;
        ba = bankNext;
        addr = a;
        dqm = m;
        dqIn = d;
    endtask

    // Idle data toggles so a stale word never looks valid
    task automatic hold(input int n, input logic en);
        ckeNext = en;
        repeat (n) issue(sdct_pkg::CMD_NOP, 13'h0000, 8'h00, ~dqIn);
    endtask

    // Run once after reset; no refresh interval is tracked
    task automatic init_seq();
        hold(INIT_CYCLES, 1'b1);
        issue(sdct_pkg::CMD_REF, 13'h0000, 8'h00, 64'h0);
        issue(sdct_pkg::CMD_REF, 13'h0000, 8'h00, 64'h0);
        hold(2, 1'b1);
    endtask

    task automatic lmr(input logic [2:0] lat, input logic [2:0] bl);
        issue(sdct_pkg::CMD_LMR, {6'h00, lat, 1'b0, bl}, 8'h00, 64'h0);
        hold(GAP_LMR, 1'b1);
    endtask

    task automatic wr(input logic [5:0] col, input logic [7:0] m, input logic [63:0] d);
        issue(sdct_pkg::CMD_WR, {7'h00, col}, m, d);
        hold(GAP_WR, 1'b1);
    endtask

    task automatic rd(input logic [5:0] col);
        issue(sdct_pkg::CMD_RD, {7'h00, col}, 8'h00, 64'h0);
    endtask

    // Clock enable high, idle clocks before the next command
    task automatic wake(input int n);
        hold(n, 1'b1);
    endtask
endmodule

// ### verif/sdct_cmd_timing_test.sv
// Self-checking testbench of the SDRAM command timing core
`timescale 1ns/1ps
module sdct_cmd_timing_test;
    localparam logic [63:0] D1 = 64'h0123456789ABCDEF;
    localparam logic [63:0] D2 = 64'hFEDCBA9876543210;
    localparam logic [63:0] D4 = 64'hC0DE00000000A004;
    localparam logic [63:0] D5 = 64'hC0DE00000000B005;

    logic        clock;
    logic        resetn;
    logic        cke;
    logic        csN;
    logic        rasN;
    logic        casN;
    logic        weN;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic [7:0]  dqm;
    logic [63:0] dqIn;
    logic [63:0] dqOut;
    logic [7:0]  dqOe;
    logic        suspended;
    logic        selfRefresh;
    logic        writeOverflow;
    int          numErrors;
    int          nChecks;

    sdct_ctrl_model ctl (.clock(clock), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
        .weN(weN), .ba(ba), .addr(addr), .dqm(dqm), .dqIn(dqIn));
    sdct_cmd_timing dut (.clock(clock), .resetn(resetn), .cke(cke), .csN(csN), .rasN(rasN),
        .casN(casN), .weN(weN), .ba(ba), .addr(addr), .dqm(dqm), .dqIn(dqIn),
        .dqOut(dqOut), .dqOe(dqOe), .suspended(suspended), .selfRefresh(selfRefresh),
        .writeOverflow(writeOverflow));

    // ==========================================================
    // Clock, steady through every access
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ==========================================================
    // Compare and verdict
    task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_mask_write();
        ctl.wr(6'h0B, 8'h00, D1);
        ctl.wr(6'h0B, 8'h0F, D2);
        ctl.hold(10, 1'b1);
        ctl.rd(6'h0B);
        ctl.hold(4, 1'b1);
        chk_bits(dqOe, 8'hFF);
        chk_data(dqOut, {D2[63:32], D1[31:0]});
        ctl.hold(1, 1'b1);
        chk_bits(dqOe, 8'h00);
    endtask

    task automatic t_back_to_back();
        // Later scenarios stay in the upper bank
        ctl.bankNext = 2'h3;
        ctl.issue(sdct_pkg::CMD_WR, 13'h0004, 8'h00, D4);
        ctl.issue(sdct_pkg::CMD_WR, 13'h0005, 8'h00, D5);
        ctl.hold(10, 1'b1);
        ctl.rd(6'h04);
        ctl.rd(6'h05);
        ctl.hold(3, 1'b1);
        chk_data(dqOut, D4);
        ctl.hold(1, 1'b1);
        chk_data(dqOut, D5);
        ctl.hold(1, 1'b1);
        chk_bits(dqOe, 8'h00);
    endtask

    task automatic t_latency2();
        ctl.lmr(3'h2, 3'h0);
        ctl.rd(6'h04);
        ctl.hold(3, 1'b1);
        chk_bits(dqOe, 8'hFF);
        chk_data(dqOut, D4);
    endtask

    task automatic t_precharge();
        for (int lat = 2; lat <= 3; lat++) begin
            ctl.lmr(lat[2:0], 3'h3);
            ctl.rd(6'h00);
            ctl.hold(1, 1'b1);
            ctl.issue(sdct_pkg::CMD_PRE, 13'h1C00, 8'h00, 64'h0);
            ctl.hold(lat, 1'b1);
            chk_bits(dqOe, 8'hFF);
            ctl.hold(1, 1'b1);
            chk_bits(dqOe, 8'h00);
        end
        ctl.lmr(3'h3, 3'h0);
    endtask

    task automatic t_suspend();
        ctl.hold(1, 1'b0);
        ctl.rd(6'h04);
        repeat (4) begin
            ctl.hold(1, 1'b0);
            chk_bits(dqOe, 8'h00);
        end
        chk_bits({7'h00, suspended}, 8'h01);
        ctl.wake(1);
        ctl.rd(6'h04);
        ctl.hold(4, 1'b1);
        chk_bits(dqOe, 8'hFF);
        chk_data(dqOut, D4);
        chk_bits({7'h00, suspended}, 8'h00);
    endtask

    task automatic t_read_mask();
        ctl.lmr(3'h3, 3'h2);
        ctl.rd(6'h00);
        ctl.hold(1, 1'b1);
        ctl.issue(sdct_pkg::CMD_NOP, 13'h0000, 8'hF1, 64'h0);
        ctl.hold(2, 1'b1);
        chk_bits(dqOe, 8'hFF);
        ctl.hold(1, 1'b1);
        chk_bits(dqOe, 8'h0E);
        ctl.hold(1, 1'b1);
        chk_bits(dqOe, 8'hFF);
    endtask

    task automatic t_self_refresh();
        ctl.hold(0, 1'b0);
        ctl.issue(sdct_pkg::CMD_REF, 13'h0000, 8'h00, 64'h0);
        ctl.hold(1, 1'b0);
        chk_bits({7'h00, selfRefresh}, 8'h01);
        ctl.wake(2);
        chk_bits({7'h00, selfRefresh}, 8'h00);
    endtask

    // Two write bursts of eight through the queue, the second stopped after four
    task automatic t_burst();
        ctl.lmr(3'h3, 3'h3);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                ctl.issue((i == 0) ? sdct_pkg::CMD_WR :
                          (p == 1 && i == 4) ? sdct_pkg::CMD_BST : sdct_pkg::CMD_NOP,
                          13'h0020, 8'h00, ((p == 0) ? D1 : D2) + i);
            end
        end
        ctl.hold(2, 1'b1);
        chk_bits({7'h00, writeOverflow}, 8'h00);
        ctl.rd(6'h20);
        ctl.hold(3, 1'b1);
        for (int i = 0; i < 8; i++) begin
            ctl.hold(1, 1'b1);
            chk_bits(dqOe, 8'hFF);
            chk_data(dqOut, ((i < 4) ? D2 : D1) + i);
        end
        ctl.hold(1, 1'b1);
        chk_bits(dqOe, 8'h00);
        chk_bits({6'h00, suspended, selfRefresh}, 8'h00);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        numErrors = 0;
        nChecks = 0;
        resetn = 1'b0;
        repeat (5) @(posedge clock);
        @(negedge clock);
        chk_data(dqOut, 64'h0);
        chk_bits({dqOe[0], suspended, selfRefresh, writeOverflow, 4'h0}, 8'h40);
        resetn = 1'b1;
        ctl.init_seq();
        t_mask_write();
        t_back_to_back();
        t_latency2();
        t_precharge();
        t_suspend();
        t_read_mask();
        t_self_refresh();
        t_burst();
        chk_bits({7'h00, writeOverflow}, 8'h00);
        print_verdict();
    end

    // Whole run is about 20k clocks; this leaves ample margin
    initial begin
        #250000;
        numErrors++;
        print_verdict();
    end
endmodule
